// *** common/dark_level_regs.vh ***
// Register offsets, field positions, reset values and timing counts for the dark-level block
`ifndef DARK_LEVEL_REGS_VH
`define DARK_LEVEL_REGS_VH

`define DARK_LEVEL_THRESHOLD_ADDR 8'h38
`define DARK_LEVEL_HYSTERESIS_ADDR 8'h39
`define SENSOR1_COUNT_LOW_ADDR 8'h40
`define SENSOR1_COUNT_HIGH_ADDR 8'h41
`define SENSOR2_COUNT_LOW_ADDR 8'h42
`define SENSOR2_COUNT_HIGH_ADDR 8'h43
`define THRESHOLD_RESET 8'h00
`define HYSTERESIS_RESET 8'h00
`define COUNT_RESET 13'h0000
`define COUNT_MAX 13'h1F40
`define COMPARE_STATUS_BIT 3
`define CURRENT_STEP_NA 540
`define CURRENT_FULL_NA 137700
`define REFRESH_MS 80
`define CLOCK_MHZ 100
`define REFRESH_CYCLES (`REFRESH_MS * 1000 * `CLOCK_MHZ)

`endif

// *** hw/dark_compare.v ***
// Dark-level threshold and hysteresis comparator for one sensor
`timescale 1ns/10ps
`default_nettype none

module dark_compare (
    input wire mclk,              // System clock
    input wire sys_rst,           // Synchronous reset, active high
    input wire enable,            // Comparison allowed
    input wire sample_valid,      // New conversion result this cycle
    input wire [12:0] current,    // Conversion result, full scale 8000
    input wire [7:0] threshold,   // Dark-level threshold code
    input wire [7:0] hysteresis,  // Dark-level hysteresis code
    output reg dark               // 1 while in the dark zone
);

    // ============================================================
    // Scale conversion
    // ============================================================
    // Codes step 0.54 uA and 255 means 137.7 uA, so one code is 8000/255 counts
    // of a 137.7 uA full scale; code*8000/255 lands within one count.
    function [13:0] code_to_count;
        input [8:0] code;
        reg [22:0] prod;
        reg [22:0] quot;
        begin
            prod = {14'h0000, code} * 23'h00_1F40;
            quot = prod / 23'h00_00FF;
            // Quotient tops out at 16000, so the bits cut here are always zero
            code_to_count = quot[13:0];
        end
    endfunction

    wire [13:0] trip_level;
    wire [13:0] release_level;
    assign trip_level = code_to_count({1'b0, threshold});
    assign release_level = code_to_count({1'b0, threshold} + {1'b0, hysteresis});

    // ============================================================
    // Comparator state
    // ============================================================
    // Held between samples so the hysteresis band stops chatter
    always @(posedge mclk) begin
        if (sys_rst) begin
            dark <= 1'b0;
        end else if (!enable) begin
            dark <= 1'b0;
        end else if (sample_valid) begin
            if ({1'b0, current} < trip_level) begin
                dark <= 1'b1;
            end else if ({1'b0, current} > release_level) begin
                dark <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// *** hw/dark_level_readout.v ***
// Dark-level comparison and phototransistor result readout
//
// Function
// - Current below threshold trips comparator into dark zone.
// - Current above threshold plus hysteresis returns to indoor zone.
// - Threshold code is linear, 0.54 uA per step, 137.7 uA top.
// - Hysteresis code uses the same linear current scale.
// - Sensor 1 result: bits 7..0 low byte, 12..8 in high byte [4:0].
// - Enabled sensor results refresh every 80 ms.
// - Result registers are read-only; writes are ignored.
// - Count never exceeds 0x1F40 (8000).
// - Sensor 2 has its own low/high pair with identical layout.
// - Sensor 2 dark comparison runs only when its enable is set.
// - Sensor 1 comparator output readable at status bit 3.
`timescale 1ns/10ps
`default_nettype none
`include "dark_level_regs.vh"

module dark_level_readout #(
    parameter REFRESH_CYCLES = `REFRESH_CYCLES  // Cycles between result refreshes
) (
    input wire mclk,                              // System clock, 100 MHz
    input wire sys_rst,                           // Synchronous reset, active high
    input wire sensor1_enable,                    // Sensor 1 powered and converting
    input wire sensor2_enable,                    // Sensor 2 powered and converting
    input wire sensor2_dark_compare_enable,       // Dark compare on sensor 2
    input wire [12:0] sensor1_conversion,         // Live converter output, sensor 1
    input wire [12:0] sensor2_conversion,         // Live converter output, sensor 2
    input wire reg_write,                         // Register write strobe
    input wire reg_read,                          // Register read strobe
    input wire [7:0] reg_addr,                    // Register address
    input wire [7:0] reg_wdata,                   // Register write data
    output reg [7:0] reg_rdata,                   // Register read data
    output reg sensor1_dark_compare_output,       // Sensor 1 dark comparator
    output reg second_sensor_comparator,          // Sensor 2 dark comparator
    output reg [7:0] sensor1_status,              // Sensor 1 status byte, bit 3 dark
    output reg sample_tick                        // Pulse when results refresh
);

    // ============================================================
    // Registers
    // ============================================================
    reg [7:0] dark_level_threshold;
    reg [7:0] dark_level_hysteresis;
    reg [12:0] sensor1_count;
    reg [12:0] sensor2_count;
    reg [26:0] refresh_timer;
    reg refresh_now;
    reg s1_valid;
    reg s2_valid;

    wire s1_dark;
    wire s2_dark;

    // Clamp so a converter overrange cannot leak above full scale
    function [12:0] clamp_count;
        input [12:0] raw;
        begin
            if (raw > `COUNT_MAX) begin
                clamp_count = `COUNT_MAX;
            end else begin
                clamp_count = raw;
            end
        end
    endfunction

    // ============================================================
    // Refresh timer
    // ============================================================
    // One free-running interval shared by both sensors keeps them in step
    always @(posedge mclk) begin
        if (sys_rst) begin
            refresh_timer <= 27'h000_0000;
            refresh_now <= 1'b0;
        end else if (refresh_timer == REFRESH_CYCLES - 1) begin
            refresh_timer <= 27'h000_0000;
            refresh_now <= 1'b1;
        end else begin
            refresh_timer <= refresh_timer + 27'h000_0001;
            refresh_now <= 1'b0;
        end
    end

    // ============================================================
    // Result capture
    // ============================================================
    // Only the timer loads results; the bus path never touches them
    always @(posedge mclk) begin
        if (sys_rst) begin
            sensor1_count <= `COUNT_RESET;
            sensor2_count <= `COUNT_RESET;
            s1_valid <= 1'b0;
            s2_valid <= 1'b0;
        end else begin
            s1_valid <= refresh_now && sensor1_enable;
            s2_valid <= refresh_now && sensor2_enable;
            if (refresh_now && sensor1_enable) begin
                sensor1_count <= clamp_count(sensor1_conversion);
            end
            if (refresh_now && sensor2_enable) begin
                sensor2_count <= clamp_count(sensor2_conversion);
            end
        end
    end

    // ============================================================
    // Writable settings
    // ============================================================
    // Result addresses fall through, so writes there are dropped
    always @(posedge mclk) begin
        if (sys_rst) begin
            dark_level_threshold <= `THRESHOLD_RESET;
            dark_level_hysteresis <= `HYSTERESIS_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                `DARK_LEVEL_THRESHOLD_ADDR: begin
                    dark_level_threshold <= reg_wdata;
                end
                `DARK_LEVEL_HYSTERESIS_ADDR: begin
                    dark_level_hysteresis <= reg_wdata;
                end
                default: begin
                    dark_level_threshold <= dark_level_threshold;
                end
            endcase
        end
    end

    // ============================================================
    // Comparators
    // ============================================================
    dark_compare u_cmp1 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .enable(sensor1_enable),
        .sample_valid(s1_valid),
        .current(sensor1_count),
        .threshold(dark_level_threshold),
        .hysteresis(dark_level_hysteresis),
        .dark(s1_dark)
    );

    // Sensor 2 is held out of the dark zone unless its enable is set
    dark_compare u_second_sensor_comparator (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .enable(sensor2_enable && sensor2_dark_compare_enable),
        .sample_valid(s2_valid),
        .current(sensor2_count),
        .threshold(dark_level_threshold),
        .hysteresis(dark_level_hysteresis),
        .dark(s2_dark)
    );

    // ============================================================
    // Outputs
    // ============================================================
    // Registered copies so every port comes straight from a flop
    always @(posedge mclk) begin
        if (sys_rst) begin
            sensor1_dark_compare_output <= 1'b0;
            second_sensor_comparator <= 1'b0;
            sensor1_status <= 8'h00;
            sample_tick <= 1'b0;
        end else begin
            sensor1_dark_compare_output <= s1_dark;
            second_sensor_comparator <= s2_dark;
            sensor1_status <= 8'h00;
            sensor1_status[`COMPARE_STATUS_BIT] <= s1_dark;
            sample_tick <= s1_valid | s2_valid;
        end
    end

    // Read data registered one cycle after the strobe; unmapped reads zero
    always @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `DARK_LEVEL_THRESHOLD_ADDR: reg_rdata <= dark_level_threshold;
                `DARK_LEVEL_HYSTERESIS_ADDR: reg_rdata <= dark_level_hysteresis;
                `SENSOR1_COUNT_LOW_ADDR: reg_rdata <= sensor1_count[7:0];
                `SENSOR1_COUNT_HIGH_ADDR: reg_rdata <= {3'b000, sensor1_count[12:8]};
                `SENSOR2_COUNT_LOW_ADDR: reg_rdata <= sensor2_count[7:0];
                `SENSOR2_COUNT_HIGH_ADDR: reg_rdata <= {3'b000, sensor2_count[12:8]};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

`default_nettype wire

// *** tb/sensor_model.sv ***
// Behavioural pair of phototransistor converters feeding the readout block
`timescale 1ns/10ps
`default_nettype none
module sensor_model (
    input wire logic mclk, // Clock
    input wire logic [12:0] level1, // Commanded light, sensor 1
    input wire logic [12:0] level2, // Commanded light, sensor 2
    output logic [12:0] conv1, // Converter count, sensor 1
    output logic [12:0] conv2 // Converter count, sensor 2
);
    // One cycle of settling; overrange passes through so the clamp is exercised
    always_ff @(posedge mclk) begin
        conv1 <= level1;
        conv2 <= level2;
    end
endmodule
`default_nettype wire

// *** tb/dark_level_readout_sva.sv ***
// Port assertions for the dark-level readout block
`timescale 1ns/10ps
`default_nettype none
module dark_level_readout_sva #(
    parameter REFRESH_CYCLES = 20 // Cycles between refreshes
) (
    input wire logic mclk, // Clock
    input wire logic sys_rst, // Sync reset
    input wire logic sensor1_enable, // Sensor 1 on
    input wire logic sensor2_enable, // Sensor 2 on
    input wire logic sensor2_dark_compare_enable, // Sensor 2 compare on
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    input wire logic [7:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic sensor1_dark_compare_output, // Sensor 1 dark
    input wire logic second_sensor_comparator, // Sensor 2 dark
    input wire logic [7:0] sensor1_status, // Status byte
    input wire logic sample_tick // Refresh pulse
);
    logic [7:0] thr_shadow;
    logic [7:0] hys_shadow;
    logic [31:0] gap;
    logic seen;
    // ==========
    // Shadows and refresh gap; the gap is trusted only while a sensor stays on
    always_ff @(posedge mclk) begin
        if (reg_write && reg_addr == 8'h38) thr_shadow <= reg_wdata;
        if (reg_write && reg_addr == 8'h39) hys_shadow <= reg_wdata;
        gap <= sample_tick ? 32'h0000_0000 : gap + 32'h0000_0001;
        seen <= (seen || sample_tick) && (sensor1_enable || sensor2_enable);
        if (sys_rst) begin
            thr_shadow <= 8'h00;
            hys_shadow <= 8'h00;
            seen <= 1'b0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_read(logic [7:0] a);
        reg_read && reg_addr == a;
    endsequence
    // ==========
    // Checks
    a_status_mirror: assert property (sensor1_status == {4'h0, sensor1_dark_compare_output, 3'h0})
        else $error("status byte does not follow sensor 1 dark output");
    a_tick_pulse: assert property (sample_tick |=> !sample_tick)
        else $error("refresh pulse too long");
    a_tick_period: assert property (sample_tick && seen |-> gap == REFRESH_CYCLES - 1)
        else $error("refresh period wrong");
    a_dark_on_tick: assert property ($rose(sensor1_dark_compare_output) |-> $past(sample_tick))
        else $error("dark state changed between refreshes");
    a_s2_gated: assert property (!sensor2_dark_compare_enable [*5] ##0 sample_tick |-> !second_sensor_comparator)
        else $error("sensor 2 dark set while compare disabled");
    a_high_reserved: assert property (s_read(8'h41) or s_read(8'h43) |=> reg_rdata[7:5] == 3'h0)
        else $error("reserved high-byte bits set");
    a_thr_readback: assert property (s_read(8'h38) |=> reg_rdata == $past(thr_shadow))
        else $error("threshold readback wrong");
    a_hys_readback: assert property (s_read(8'h39) |=> reg_rdata == $past(hys_shadow))
        else $error("hysteresis readback wrong");
endmodule
bind dark_level_readout dark_level_readout_sva #(.REFRESH_CYCLES(REFRESH_CYCLES)) chk_u (
    .mclk, .sys_rst, .sensor1_enable, .sensor2_enable, .sensor2_dark_compare_enable, .reg_write,
    .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .sensor1_dark_compare_output,
    .second_sensor_comparator, .sensor1_status, .sample_tick);
`default_nettype wire

// *** tb/dark_level_readout_bench.sv ***
// Self-checking bench for the dark-level readout block
`timescale 1ns/10ps
`default_nettype none
module dark_level_readout_bench;
    logic mclk = 1'b0, sys_rst = 1'b1, en1 = 1'b0, en2 = 1'b0, c2en = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, status;
    logic [12:0] lvl1 = 13'h0000, lvl2 = 13'h0000, conv1, conv2;
    logic dark1, dark2, tick;
    int bad_count = 0, total_checks = 0, cycles = 0;
    int lo = 64 * 8000 / 255, hi = 80 * 8000 / 255;
    initial forever #5 mclk = ~mclk;
    sensor_model model_u (.mclk(mclk), .level1(lvl1), .level2(lvl2), .conv1(conv1), .conv2(conv2));
    dark_level_readout #(.REFRESH_CYCLES(20)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
        .sensor1_enable(en1), .sensor2_enable(en2), .sensor2_dark_compare_enable(c2en),
        .sensor1_conversion(conv1), .sensor2_conversion(conv2), .reg_write(wr), .reg_read(rd),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .sensor1_dark_compare_output(dark1),
        .second_sensor_comparator(dark2), .sensor1_status(status), .sample_tick(tick));
    // ==========
    // Shared tasks
    task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // Read data is registered, so it is taken one edge after the strobe is seen
    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        {rd, addr} <= {1'b1, a};
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        compare($sformatf("reg %h", a), exp, rdata);
    endtask
    task automatic check_count(input logic [7:0] a, input logic [12:0] v);
        check_reg(a, v[7:0]);
        check_reg(a + 8'h01, {3'h0, v[12:8]});
    endtask
    // Two refreshes, because the first may have sampled before the new light
    task automatic light(input logic [12:0] l1, input logic [12:0] l2);
        @(posedge mclk);
        {lvl1, lvl2} <= {l1, l2};
        repeat (2) begin
            @(posedge mclk);
            while (tick !== 1'b1) @(posedge mclk);
        end
        // Dark outputs are loaded on the edge after the pulse
        @(posedge mclk);
    endtask
    task automatic check_dark(input logic e1, input logic e2);
        compare("sensor1 dark", {7'h00, e1}, {7'h00, dark1});
        compare("status", {4'h0, e1, 3'h0}, status);
        compare("sensor2 dark", {7'h00, e2}, {7'h00, dark2});
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========
    // Scenarios
    task automatic test_regs;
        for (int a = 8'h38; a <= 8'h50; a++) check_reg(a[7:0], 8'h00);
        write_reg(8'h38, 8'ha5);
        check_reg(8'h38, 8'ha5);
        write_reg(8'h39, 8'h5a);
        check_reg(8'h39, 8'h5a);
        for (int a = 8'h40; a <= 8'h43; a++) begin
            write_reg(a[7:0], 8'hff);
            check_reg(a[7:0], 8'h00);
        end
        check_reg(8'h38, 8'ha5);
        $display("test registers done");
    endtask
    task automatic test_counts;
        @(posedge mclk);
        {en1, en2} <= 2'b11;
        light(13'h1abc, 13'h0123);
        check_count(8'h40, 13'h1abc);
        check_count(8'h42, 13'h0123);
        light(13'h1fff, 13'h1f41);
        check_count(8'h40, 13'h1f40);
        check_count(8'h42, 13'h1f40);
        en1 <= 1'b0;
        light(13'h0555, 13'h0777);
        check_count(8'h40, 13'h1f40);
        check_count(8'h42, 13'h0777);
        $display("test counts done");
    endtask
    task automatic test_dark;
        write_reg(8'h38, 8'h40);
        write_reg(8'h39, 8'h10);
        en1 <= 1'b1;
        light(13'(lo - 1), 13'(lo - 1));
        check_dark(1'b1, 1'b0);
        c2en <= 1'b1;
        light(13'(hi), 13'(lo - 1));
        check_dark(1'b1, 1'b1);
        light(13'(hi + 1), 13'(lo));
        check_dark(1'b0, 1'b1);
        c2en <= 1'b0;
        light(13'(lo), 13'(lo - 1));
        check_dark(1'b0, 1'b0);
        $display("test dark done");
    endtask
    // Hang guard; the scenarios need well under a tenth of this
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        test_regs();
        test_counts();
        test_dark();
        print_verdict();
    end
endmodule
`default_nettype wire
